// file: verilog/gpio_defs.svh
// Purpose: Offsets, field positions and reset values of the port block
// Assumes: Eight-bit I/O space with six address bits
// Notes: Definitions only
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// ============================================================
// I/O space
`define IO_ADDR_W 6
`define IO_DATA_W 8

// ============================================================
// Pin-change masks
`define ADDR_PC_MASK_G1 6'h04
`define ADDR_PC_MASK_G2 6'h05
`define ADDR_PC_MASK_G0 6'h20
`define PC_MASK_G1_USED 8'h07
`define PC_MASK_G2_USED 8'h7F
`define PC_MASK_G0_USED 8'hFF

// ============================================================
// Core control, interrupt enable and flag registers
`define ADDR_CORE_CTRL 6'h35
`define ADDR_IRQ_FLAG 6'h3A
`define ADDR_IRQ_ENABLE 6'h3B
`define BIT_PULLUP_DISABLE 7
`define BIT_GROUP0 5
`define BIT_GROUP2 4
`define BIT_GROUP1 3
`define IRQ_ENABLE_USED 8'hF8

// ============================================================
// Port register triplets
`define ADDR_PORTA_LATCH 6'h1B
`define ADDR_PORTA_DIR 6'h1A
`define ADDR_PORTA_PIN 6'h19
`define ADDR_PORTB_LATCH 6'h18
`define ADDR_PORTB_DIR 6'h17
`define ADDR_PORTB_PIN 6'h16
`define ADDR_PORTD_LATCH 6'h12
`define ADDR_PORTD_DIR 6'h11
`define ADDR_PORTD_PIN 6'h10

// ============================================================
// Widths and reset values
`define PORTA_W 3
`define PORTB_W 8
`define PORTD_W 7
`define REG_RESET 8'h00

`endif

// file: verilog/gpio_pkg.sv
// Purpose: Shared types of the port block
// Assumes: gpio_defs.svh holds the I/O widths; the three-bit isr_ack width is set here
// Notes: Types only
`include "gpio_defs.svh"

package gpio_pkg;

   // ============================================================
   // I/O space access from the core
   typedef struct packed {
      logic [`IO_ADDR_W-1:0] addr;
      logic [`IO_DATA_W-1:0] wdata;
      logic we;
      logic re;
   } io_req_t;

   // ============================================================
   // Core interrupt handshake
   typedef struct packed {
      logic gie;
      logic [2:0] isr_ack;
   } core_irq_t;

endpackage : gpio_pkg

// file: verilog/pin_sync.sv
// Purpose: Two-stage pin synchroniser plus previous-sample stage
// Assumes: Pins may change at any time
// Notes: First stage read only by the second
`timescale 1ns/1ps

module pin_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Pins and samples
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o,
   output logic [W-1:0] prev_o
);

   // ============================================================
   // Fill marker: prev shows the fresh sample until the stages hold
   // real levels, so leaving reset raises no false change; a genuine
   // change in those first cycles is lost
   logic [2:0] fill_q;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         fill_q <= 3'b000;
      end else begin
         fill_q <= {fill_q[1:0], 1'b1};
      end
   end

   // ============================================================
   // Per-pin stages
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic sync_q;
         logic prev_q;
         always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
               prev_q <= 1'b0;
            end else begin
               meta_q <= pin_i[g];
               sync_q <= meta_q;
               prev_q <= sync_q;
            end
         end
         assign sync_o[g] = sync_q;
         assign prev_o[g] = fill_q[2] ? prev_q : sync_q;
      end
   endgenerate

endmodule : pin_sync

// file: verilog/port_regs.sv
// Purpose: Output latch and direction registers of one port
// Assumes: One access at most per cycle
// Notes: Pin location toggles the latch on written ones
`timescale 1ns/1ps
`include "gpio_defs.svh"

module port_regs #(
   parameter int W = 8,
   parameter logic [`IO_ADDR_W-1:0] A_LATCH = `IO_ADDR_W'h00,
   parameter logic [`IO_ADDR_W-1:0] A_DIR = `IO_ADDR_W'h01,
   parameter logic [`IO_ADDR_W-1:0] A_PIN = `IO_ADDR_W'h02
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // I/O access
   input wire gpio_pkg::io_req_t req_i,
   input wire logic [W-1:0] pin_sync_i,
   output logic [`IO_DATA_W-1:0] rdata_o,
   output logic hit_o,
   // Pin controls
   output logic [W-1:0] latch_o,
   output logic [W-1:0] dir_o
);

   logic [W-1:0] latch_q;
   logic [W-1:0] dir_q;
   logic [W-1:0] wbits;

   assign wbits = req_i.wdata[W-1:0];

   // ============================================================
   // Latch: plain write or toggle, each bit on its own
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         latch_q <= '0;
      end else if (req_i.we && req_i.addr == A_LATCH) begin
         latch_q <= wbits;
      end else if (req_i.we && req_i.addr == A_PIN) begin
         latch_q <= latch_q ^ wbits;
      end
   end

   // ============================================================
   // Direction
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dir_q <= '0;
      end else if (req_i.we && req_i.addr == A_DIR) begin
         dir_q <= wbits;
      end
   end

   // ============================================================
   // Read mux, unused upper bits read zero
   always_comb begin
      rdata_o = '0;
      hit_o = 1'b1;
      case (req_i.addr)
         A_LATCH: rdata_o[W-1:0] = latch_q;
         A_DIR: rdata_o[W-1:0] = dir_q;
         A_PIN: rdata_o[W-1:0] = pin_sync_i;
         default: hit_o = 1'b0;
      endcase
   end

   assign latch_o = latch_q;
   assign dir_o = dir_q;

endmodule : port_regs

// file: verilog/gpio_port_pin_change_irq.sv
// Purpose: Three GPIO ports with pin-change interrupt groups
// Assumes: Core drives one I/O access per cycle; bus inputs synchronous, pins synchronised here
// Notes: Read data is registered one cycle after the read strobe
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_port_pin_change_irq #(
   parameter int PA_W = `PORTA_W,
   parameter int PB_W = `PORTB_W,
   parameter int PD_W = `PORTD_W
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // I/O space access
   input wire gpio_pkg::io_req_t io_req_i,
   output logic [`IO_DATA_W-1:0] io_rdata_o,
   // Core interrupt interface
   input wire gpio_pkg::core_irq_t core_i,
   output logic [2:0] irq_o,
   // Port A pins (group 1)
   input wire logic [PA_W-1:0] pa_in_i,
   output logic [PA_W-1:0] pa_out_o,
   output logic [PA_W-1:0] pa_oe_o,
   output logic [PA_W-1:0] pa_pullup_o,
   // Port B pins (group 0)
   input wire logic [PB_W-1:0] pb_in_i,
   output logic [PB_W-1:0] pb_out_o,
   output logic [PB_W-1:0] pb_oe_o,
   output logic [PB_W-1:0] pb_pullup_o,
   // Port D pins (group 2)
   input wire logic [PD_W-1:0] pd_in_i,
   output logic [PD_W-1:0] pd_out_o,
   output logic [PD_W-1:0] pd_oe_o,
   output logic [PD_W-1:0] pd_pullup_o
);

   // ============================================================
   // Declarations
   logic [`IO_DATA_W-1:0] mask_g0_q;
   logic [`IO_DATA_W-1:0] mask_g1_q;
   logic [`IO_DATA_W-1:0] mask_g2_q;
   logic [`IO_DATA_W-1:0] core_ctrl_q;
   logic [`IO_DATA_W-1:0] irq_en_q;
   logic [2:0] flag_q;
   logic [2:0] flag_d;
   logic [2:0] grp_en;
   logic [2:0] change;
   logic [2:0] flag_wclr;
   logic [2:0] irq_d;
   logic [2:0] irq_q;
   logic global_pullup_disable;
   logic [`IO_DATA_W-1:0] rdata_d;
   logic [`IO_DATA_W-1:0] rdata_q;

   logic [PA_W-1:0] pa_sync;
   logic [PA_W-1:0] pa_prev;
   logic [PB_W-1:0] pb_sync;
   logic [PB_W-1:0] pb_prev;
   logic [PD_W-1:0] pd_sync;
   logic [PD_W-1:0] pd_prev;

   logic [PA_W-1:0] pa_latch;
   logic [PA_W-1:0] pa_dir;
   logic [PB_W-1:0] pb_latch;
   logic [PB_W-1:0] pb_dir;
   logic [PD_W-1:0] pd_latch;
   logic [PD_W-1:0] pd_dir;

   logic [`IO_DATA_W-1:0] pa_rdata;
   logic [`IO_DATA_W-1:0] pb_rdata;
   logic [`IO_DATA_W-1:0] pd_rdata;
   logic pa_hit;
   logic pb_hit;
   logic pd_hit;

   logic [PA_W-1:0] pa_out_q;
   logic [PA_W-1:0] pa_oe_q;
   logic [PA_W-1:0] pa_pu_q;
   logic [PB_W-1:0] pb_out_q;
   logic [PB_W-1:0] pb_oe_q;
   logic [PB_W-1:0] pb_pu_q;
   logic [PD_W-1:0] pd_out_q;
   logic [PD_W-1:0] pd_oe_q;
   logic [PD_W-1:0] pd_pu_q;

   logic wr;

   assign wr = io_req_i.we;

   // ============================================================
   // Pin synchronisers
   pin_sync #(
      .W(PA_W)
   ) u_sync_a (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pa_in_i),
      .sync_o(pa_sync),
      .prev_o(pa_prev)
   );

   pin_sync #(
      .W(PB_W)
   ) u_sync_b (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pb_in_i),
      .sync_o(pb_sync),
      .prev_o(pb_prev)
   );

   pin_sync #(
      .W(PD_W)
   ) u_sync_d (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pd_in_i),
      .sync_o(pd_sync),
      .prev_o(pd_prev)
   );

   // ============================================================
   // Port registers
   port_regs #(
      .W(PA_W),
      .A_LATCH(`ADDR_PORTA_LATCH),
      .A_DIR(`ADDR_PORTA_DIR),
      .A_PIN(`ADDR_PORTA_PIN)
   ) u_port_a (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .req_i(io_req_i),
      .pin_sync_i(pa_sync),
      .rdata_o(pa_rdata),
      .hit_o(pa_hit),
      .latch_o(pa_latch),
      .dir_o(pa_dir)
   );

   port_regs #(
      .W(PB_W),
      .A_LATCH(`ADDR_PORTB_LATCH),
      .A_DIR(`ADDR_PORTB_DIR),
      .A_PIN(`ADDR_PORTB_PIN)
   ) u_port_b (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .req_i(io_req_i),
      .pin_sync_i(pb_sync),
      .rdata_o(pb_rdata),
      .hit_o(pb_hit),
      .latch_o(pb_latch),
      .dir_o(pb_dir)
   );

   port_regs #(
      .W(PD_W),
      .A_LATCH(`ADDR_PORTD_LATCH),
      .A_DIR(`ADDR_PORTD_DIR),
      .A_PIN(`ADDR_PORTD_PIN)
   ) u_port_d (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .req_i(io_req_i),
      .pin_sync_i(pd_sync),
      .rdata_o(pd_rdata),
      .hit_o(pd_hit),
      .latch_o(pd_latch),
      .dir_o(pd_dir)
   );

   // ============================================================
   // Pin-change masks
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mask_g0_q <= `REG_RESET;
      end else if (wr && io_req_i.addr == `ADDR_PC_MASK_G0) begin
         mask_g0_q <= io_req_i.wdata & `PC_MASK_G0_USED;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mask_g1_q <= `REG_RESET;
      end else if (wr && io_req_i.addr == `ADDR_PC_MASK_G1) begin
         mask_g1_q <= io_req_i.wdata & `PC_MASK_G1_USED;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mask_g2_q <= `REG_RESET;
      end else if (wr && io_req_i.addr == `ADDR_PC_MASK_G2) begin
         mask_g2_q <= io_req_i.wdata & `PC_MASK_G2_USED;
      end
   end

   // ============================================================
   // Core control and interrupt enable
   // Other core control bits and enable bits 7:6 are kept as storage for neighbouring blocks; enable bits 2:0 read zero
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         core_ctrl_q <= `REG_RESET;
      end else if (wr && io_req_i.addr == `ADDR_CORE_CTRL) begin
         core_ctrl_q <= io_req_i.wdata;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         irq_en_q <= `REG_RESET;
      end else if (wr && io_req_i.addr == `ADDR_IRQ_ENABLE) begin
         irq_en_q <= io_req_i.wdata & `IRQ_ENABLE_USED;
      end
   end

   assign global_pullup_disable = core_ctrl_q[`BIT_PULLUP_DISABLE];
   assign grp_en[0] = irq_en_q[`BIT_GROUP0];
   assign grp_en[1] = irq_en_q[`BIT_GROUP1];
   assign grp_en[2] = irq_en_q[`BIT_GROUP2];

   // ============================================================
   // Change detection, masked and ORed per group
   assign change[0] = grp_en[0] &
      (|((pb_sync ^ pb_prev) & mask_g0_q[PB_W-1:0]));
   assign change[1] = grp_en[1] &
      (|((pa_sync ^ pa_prev) & mask_g1_q[PA_W-1:0]));
   assign change[2] = grp_en[2] &
      (|((pd_sync ^ pd_prev) & mask_g2_q[PD_W-1:0]));

   // ============================================================
   // Group flags: a new change wins over any clear in the same cycle
   always_comb begin
      flag_wclr = 3'b000;
      if (wr && io_req_i.addr == `ADDR_IRQ_FLAG) begin
         flag_wclr[0] = io_req_i.wdata[`BIT_GROUP0];
         flag_wclr[1] = io_req_i.wdata[`BIT_GROUP1];
         flag_wclr[2] = io_req_i.wdata[`BIT_GROUP2];
      end
      flag_d = (flag_q & ~flag_wclr & ~core_i.isr_ack) | change;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         flag_q <= 3'b000;
      end else begin
         flag_q <= flag_d;
      end
   end

   // ============================================================
   // Requests to the core
   assign irq_d = flag_d & grp_en & {3{core_i.gie}};

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         irq_q <= 3'b000;
      end else begin
         irq_q <= irq_d;
      end
   end

   // ============================================================
   // Pin drive: registered; enables and pull-ups then gated by reset without a clock edge
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pa_oe_q <= '0;
         pb_oe_q <= '0;
         pd_oe_q <= '0;
      end else begin
         pa_oe_q <= pa_dir;
         pb_oe_q <= pb_dir;
         pd_oe_q <= pd_dir;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pa_out_q <= '0;
         pb_out_q <= '0;
         pd_out_q <= '0;
      end else begin
         pa_out_q <= pa_latch;
         pb_out_q <= pb_latch;
         pd_out_q <= pd_latch;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pa_pu_q <= '0;
         pb_pu_q <= '0;
         pd_pu_q <= '0;
      end else begin
         pa_pu_q <= ~pa_dir & pa_latch & {PA_W{~global_pullup_disable}};
         pb_pu_q <= ~pb_dir & pb_latch & {PB_W{~global_pullup_disable}};
         pd_pu_q <= ~pd_dir & pd_latch & {PD_W{~global_pullup_disable}};
      end
   end

   // Only an AND after the flop, so reset floats pins with no clock
   assign pa_oe_o = pa_oe_q & {PA_W{~sys_rst_i}};
   assign pb_oe_o = pb_oe_q & {PB_W{~sys_rst_i}};
   assign pd_oe_o = pd_oe_q & {PD_W{~sys_rst_i}};
   assign pa_pullup_o = pa_pu_q & {PA_W{~sys_rst_i}};
   assign pb_pullup_o = pb_pu_q & {PB_W{~sys_rst_i}};
   assign pd_pullup_o = pd_pu_q & {PD_W{~sys_rst_i}};
   assign pa_out_o = pa_out_q;
   assign pb_out_o = pb_out_q;
   assign pd_out_o = pd_out_q;

   // ============================================================
   // Read data
   always_comb begin
      rdata_d = `REG_RESET;
      if (pa_hit) begin
         rdata_d = pa_rdata;
      end else if (pb_hit) begin
         rdata_d = pb_rdata;
      end else if (pd_hit) begin
         rdata_d = pd_rdata;
      end else begin
         case (io_req_i.addr)
            `ADDR_PC_MASK_G0: rdata_d = mask_g0_q;
            `ADDR_PC_MASK_G1: rdata_d = mask_g1_q;
            `ADDR_PC_MASK_G2: rdata_d = mask_g2_q;
            `ADDR_CORE_CTRL: rdata_d = core_ctrl_q;
            `ADDR_IRQ_ENABLE: rdata_d = irq_en_q;
            `ADDR_IRQ_FLAG: begin
               rdata_d[`BIT_GROUP0] = flag_q[0];
               rdata_d[`BIT_GROUP1] = flag_q[1];
               rdata_d[`BIT_GROUP2] = flag_q[2];
            end
            default: rdata_d = `REG_RESET;
         endcase
      end
   end

   // Held between reads so the core may sample late
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdata_q <= `REG_RESET;
      end else if (io_req_i.re) begin
         rdata_q <= rdata_d;
      end
   end

   assign io_rdata_o = rdata_q;
   assign irq_o = irq_q;

endmodule : gpio_port_pin_change_irq

// file: verif/gpio_monitor.sv
// Purpose: Port-level checks of the GPIO and pin-change block
// Assumes: Sees only the top ports
// Notes: Quiet counter keeps clears apart from fresh pin changes
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_monitor #(
   parameter int PA_W = 3,
   parameter int PB_W = 8,
   parameter int PD_W = 7
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Bus and core
   input wire gpio_pkg::io_req_t io_req_i,
   input wire logic [`IO_DATA_W-1:0] io_rdata_o,
   input wire gpio_pkg::core_irq_t core_i,
   input wire logic [2:0] irq_o,
   // Pins
   input wire logic [PA_W-1:0] pa_in_i,
   input wire logic [PA_W-1:0] pa_out_o,
   input wire logic [PA_W-1:0] pa_oe_o,
   input wire logic [PA_W-1:0] pa_pullup_o,
   input wire logic [PB_W-1:0] pb_in_i,
   input wire logic [PB_W-1:0] pb_out_o,
   input wire logic [PB_W-1:0] pb_oe_o,
   input wire logic [PB_W-1:0] pb_pullup_o,
   input wire logic [PD_W-1:0] pd_in_i,
   input wire logic [PD_W-1:0] pd_out_o,
   input wire logic [PD_W-1:0] pd_oe_o,
   input wire logic [PD_W-1:0] pd_pullup_o
);
   // ==========
   // Helpers
   logic [PA_W+PB_W+PD_W-1:0] pins_q;
   logic [2:0] quiet_q;
   logic wr_ctl, wr_dirb, wr_latd, wr_flag;
   assign wr_ctl = io_req_i.we && io_req_i.addr == `ADDR_CORE_CTRL;
   assign wr_dirb = io_req_i.we && io_req_i.addr == `ADDR_PORTB_DIR;
   assign wr_latd = io_req_i.we && (io_req_i.addr == `ADDR_PORTD_LATCH ||
      io_req_i.addr == `ADDR_PORTD_PIN);
   assign wr_flag = io_req_i.we && io_req_i.addr == `ADDR_IRQ_FLAG;
   // A flag set in flight wins over a clear, so clears need calm pins
   always_ff @(posedge mclk_i) begin
      pins_q <= {pa_in_i, pb_in_i, pd_in_i};
      if (sys_rst_i || {pa_in_i, pb_in_i, pd_in_i} != pins_q) quiet_q <= 3'h0;
      else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
   end

   // ==========
   // Assertions
   reset_tri_a: assert property (
      @(posedge mclk_i) sys_rst_i |-> {pa_oe_o, pb_oe_o, pd_oe_o,
      pa_pullup_o, pb_pullup_o, pd_pullup_o} == '0)
      else $error("pins driven in reset");
   reset_clear_a: assert property (
      @(posedge mclk_i) sys_rst_i |=> {irq_o, pb_out_o, io_rdata_o} == '0)
      else $error("state not cleared by reset");
   irq_gie_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_o != 3'h0 |-> $past(core_i.gie))
      else $error("request without global enable");
   isr_clear_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      core_i.isr_ack != 3'h0 && quiet_q >= 3'h3
      |=> (irq_o & $past(core_i.isr_ack)) == 3'h0)
      else $error("service entry left request up");
   flag_w1c_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      wr_flag && quiet_q >= 3'h3 |=> (irq_o &
      $past({io_req_i.wdata[`BIT_GROUP2], io_req_i.wdata[`BIT_GROUP1],
      io_req_i.wdata[`BIT_GROUP0]})) == 3'h0)
      else $error("write one did not clear flag");
   dir_drive_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      wr_dirb ##1 !wr_dirb |=> pb_oe_o == $past(io_req_i.wdata, 2))
      else $error("driver enable differs from direction");
   latch_drive_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      (wr_latd && io_req_i.addr == `ADDR_PORTD_LATCH) ##1 !wr_latd
      |=> pd_out_o == $past(io_req_i.wdata[PD_W-1:0], 2))
      else $error("drive value differs from latch");
   pullup_cfg_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      1'b1 |-> (pb_pullup_o & (pb_oe_o | ~pb_out_o)) == '0)
      else $error("pull-up on output or zero latch");
   pud_off_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      (wr_ctl && io_req_i.wdata[`BIT_PULLUP_DISABLE]) ##1 !wr_ctl
      |=> {pa_pullup_o, pb_pullup_o, pd_pullup_o} == '0)
      else $error("pull-up on while disabled");
   g1_rsvd_a: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      io_req_i.re && io_req_i.addr == `ADDR_PC_MASK_G1
      |=> io_rdata_o[7:3] == 5'h00)
      else $error("reserved mask bits read nonzero");
endmodule : gpio_monitor

bind gpio_port_pin_change_irq gpio_monitor #(.PA_W(PA_W), .PB_W(PB_W),
   .PD_W(PD_W)) gpio_monitor_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
   .io_req_i(io_req_i), .io_rdata_o(io_rdata_o), .core_i(core_i),
   .irq_o(irq_o), .pa_in_i(pa_in_i), .pa_out_o(pa_out_o),
   .pa_oe_o(pa_oe_o), .pa_pullup_o(pa_pullup_o), .pb_in_i(pb_in_i),
   .pb_out_o(pb_out_o), .pb_oe_o(pb_oe_o), .pb_pullup_o(pb_pullup_o),
   .pd_in_i(pd_in_i), .pd_out_o(pd_out_o), .pd_oe_o(pd_oe_o),
   .pd_pullup_o(pd_pullup_o));

// file: verif/pin_circuit.sv
// Purpose: External circuit on the pins of one port
// Assumes: Bench picks which pins it drives and to what level
// Notes: Device driver wins; an undriven bare pin toggles every cycle
`timescale 1ns/1ps

module pin_circuit #(
   parameter int W = 8
) (
   // Clock
   input wire logic mclk_i,
   // Device side
   input wire logic [W-1:0] out_i,
   input wire logic [W-1:0] oe_i,
   input wire logic [W-1:0] pullup_i,
   // Bench control
   input wire logic [W-1:0] drv_en_i,
   input wire logic [W-1:0] drv_val_i,
   // Resolved level
   output logic [W-1:0] level_o
);
   // ==========
   // Wire level
   logic [W-1:0] float_q = '0;
   // Floating pins keep moving so no stale level passes as real
   always_ff @(posedge mclk_i) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (oe_i[i]) level_o[i] = out_i[i];
         else if (drv_en_i[i]) level_o[i] = drv_val_i[i];
         else if (pullup_i[i]) level_o[i] = 1'b1;
         else level_o[i] = float_q[i];
      end
   end
endmodule : pin_circuit

// file: verif/gpio_port_pin_change_irq_test.sv
// Purpose: Self-checking bench of the GPIO and pin-change block
// Assumes: Latencies as handed over; no random stimulus
// Notes: Register cases run from a table, odd cases by hand
`timescale 1ns/1ps
`include "gpio_defs.svh"

`define CHK(got, exp) begin \
   tests_run++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[ERR] %0t got %h want %h", $time, got, exp); \
   end \
end

module gpio_port_pin_change_irq_test;
   // ==========
   // Signals
   typedef struct {
      logic [5:0] addr;
      logic [7:0] wd;
      logic [7:0] exp;
   } row_t;
   row_t rows [9];
   logic mclk_i;
   logic sys_rst_i;
   gpio_pkg::io_req_t req;
   gpio_pkg::core_irq_t core;
   logic [7:0] rdata, d;
   logic [2:0] irq;
   logic [2:0] pa_in, pa_out, pa_oe, pa_pu, pa_den, pa_dval;
   logic [7:0] pb_in, pb_out, pb_oe, pb_pu, pb_den, pb_dval;
   logic [6:0] pd_in, pd_out, pd_oe, pd_pu, pd_den, pd_dval;
   int error_cnt = 0;
   int tests_run = 0;

   gpio_port_pin_change_irq gpio_port_pin_change_irq_i (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .io_req_i(req), .io_rdata_o(rdata),
      .core_i(core), .irq_o(irq), .pa_in_i(pa_in), .pa_out_o(pa_out),
      .pa_oe_o(pa_oe), .pa_pullup_o(pa_pu), .pb_in_i(pb_in),
      .pb_out_o(pb_out), .pb_oe_o(pb_oe), .pb_pullup_o(pb_pu),
      .pd_in_i(pd_in), .pd_out_o(pd_out), .pd_oe_o(pd_oe),
      .pd_pullup_o(pd_pu));
   pin_circuit #(.W(3)) pa_circuit_i (.mclk_i(mclk_i), .out_i(pa_out),
      .oe_i(pa_oe), .pullup_i(pa_pu), .drv_en_i(pa_den),
      .drv_val_i(pa_dval), .level_o(pa_in));
   pin_circuit #(.W(8)) pb_circuit_i (.mclk_i(mclk_i), .out_i(pb_out),
      .oe_i(pb_oe), .pullup_i(pb_pu), .drv_en_i(pb_den),
      .drv_val_i(pb_dval), .level_o(pb_in));
   pin_circuit #(.W(7)) pd_circuit_i (.mclk_i(mclk_i), .out_i(pd_out),
      .oe_i(pd_oe), .pullup_i(pd_pu), .drv_en_i(pd_den),
      .drv_val_i(pd_dval), .level_o(pd_in));

   // ==========
   // Tasks
   task automatic complete_run();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
      @(posedge mclk_i);
      req.we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge mclk_i);
      req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge mclk_i);
      req.re <= 1'b0;
      #1 v = rdata;
   endtask : rd

   task automatic flip(input int p, input int b);
      @(posedge mclk_i);
      case (p)
         0: pb_dval[b] <= ~pb_dval[b];
         1: pa_dval[b] <= ~pa_dval[b];
         default: pd_dval[b] <= ~pd_dval[b];
      endcase
   endtask : flip

   // Bounded wait; running out ends the run as a mismatch
   task automatic expect_irq(input logic [2:0] e);
      int n;
      n = 0;
      tests_run++;
      while (irq !== e && n < 8) begin
         @(posedge mclk_i);
         #1 n++;
      end
      if (irq !== e) begin
         error_cnt++;
         $display("[ERR] %0t request not seen", $time);
         complete_run();
      end
   endtask : expect_irq

   task automatic ack(input logic [2:0] g);
      @(posedge mclk_i);
      core.isr_ack <= g;
      @(posedge mclk_i);
      core.isr_ack <= 3'h0;
      #1 `CHK(irq, 3'h0)
   endtask : ack

   // ==========
   // Clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // ==========
   // Sequence
   initial begin
      sys_rst_i = 1'b1;
      req = '0;
      core = '0;
      {pa_den, pb_den, pd_den} = '1;
      {pa_dval, pb_dval, pd_dval} = {3'h0, 8'h5A, 7'h00};
      rows = '{'{`ADDR_PC_MASK_G1, 8'hFF, 8'h07},
         '{`ADDR_PC_MASK_G2, 8'hFF, 8'h7F},
         '{`ADDR_PC_MASK_G0, 8'hA5, 8'hA5},
         '{`ADDR_IRQ_ENABLE, 8'hFF, 8'hF8},
         '{`ADDR_PORTA_DIR, 8'h05, 8'h05},
         '{`ADDR_PORTD_DIR, 8'h55, 8'h55},
         '{`ADDR_PORTD_LATCH, 8'h2A, 8'h2A},
         '{`ADDR_CORE_CTRL, 8'h40, 8'h40},
         '{6'h2A, 8'hFF, 8'h00}};
      repeat (6) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wd);
         rd(rows[i].addr, d);
         `CHK(d, rows[i].exp)
      end
      `CHK({pa_oe, pa_out, pa_pu}, 9'h140)
      `CHK({pd_oe, pd_out, pd_pu}, 21'h15552A)
      // Pull-up step first, never straight from high-Z to driven high
      wr(`ADDR_PORTB_LATCH, 8'h0F);
      wr(`ADDR_PORTB_DIR, 8'h0F);
      repeat (3) @(posedge mclk_i);
      `CHK({pb_oe, pb_out, pb_pu}, 24'h0F0F00)
      rd(`ADDR_PORTB_PIN, d);
      `CHK(d, 8'h5F)
      wr(`ADDR_PORTB_PIN, 8'h81);
      rd(`ADDR_PORTB_LATCH, d);
      `CHK(d, 8'h8E)
      `CHK({pb_oe, pb_out, pb_pu}, 24'h0F8E80)
      wr(`ADDR_CORE_CTRL, 8'hC0);
      repeat (2) @(posedge mclk_i);
      `CHK(pb_pu, 8'h00)
      wr(`ADDR_CORE_CTRL, 8'h40);
      repeat (2) @(posedge mclk_i);
      `CHK(pb_pu, 8'h80)
      pb_den <= 8'h7F;
      rd(`ADDR_PORTB_PIN, d);
      repeat (3) @(posedge mclk_i);
      rd(`ADDR_PORTB_PIN, d);
      `CHK(d, 8'hDE)
      // Pin-change groups
      wr(`ADDR_IRQ_FLAG, 8'h38);
      flip(0, 6);
      repeat (5) @(posedge mclk_i);
      rd(`ADDR_IRQ_FLAG, d);
      `CHK(d, 8'h00)
      flip(0, 5);
      repeat (5) @(posedge mclk_i);
      rd(`ADDR_IRQ_FLAG, d);
      `CHK({d, irq}, 11'h100)
      @(posedge mclk_i) core.gie <= 1'b1;
      expect_irq(3'h1);
      ack(3'h1);
      rd(`ADDR_IRQ_FLAG, d);
      `CHK(d, 8'h00)
      flip(1, 1);
      expect_irq(3'h2);
      wr(`ADDR_IRQ_FLAG, 8'h00);
      #1 `CHK(irq, 3'h2)
      wr(`ADDR_IRQ_FLAG, 8'h08);
      #1 `CHK(irq, 3'h0)
      flip(2, 5);
      expect_irq(3'h4);
      ack(3'h4);
      wr(`ADDR_IRQ_ENABLE, 8'hE8);
      flip(2, 5);
      repeat (5) @(posedge mclk_i);
      rd(`ADDR_IRQ_FLAG, d);
      `CHK({d, irq}, 11'h000)
      // Reset in mid-run releases pins before any edge acts
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      #1 `CHK({pa_oe, pb_oe, pd_oe, pb_pu}, 26'h0)
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      rd(`ADDR_PC_MASK_G0, d);
      `CHK({d, irq, pb_out}, 19'h0)
      complete_run();
   end
endmodule : gpio_port_pin_change_irq_test
